// File: src/mdc_clear_pulse.sv
// Fault clear pulse register: the pulse follows the trigger one cycle later.
`timescale 1ns/10ps
module mdc_clear_pulse (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic trigger,
  output logic pulse
);
  import mdc_pkg::*;

  // ****************************************************************
  // Pulse register.
  // ****************************************************************

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pulse <= 1'b0;
    end else begin
      pulse <= trigger;
    end
  end
endmodule

// File: src/mdc_control_regs.sv
// Top of the motor driver control register bank with decoded setting outputs.
`timescale 1ns/10ps

// Notes on behaviour
// - Bit 5 selects open-drain or push-pull output.
// - Slew code selects 25, 50, 125, 200.
// - Mode code picks rectification and Hall type.
// - Writing one clears faults, bit self-clears.
// - Full-duty frequency 20 kHz or 40 kHz.
// - Overvoltage level 34 V or 22 V.
// - Overvoltage protection enable, resets enabled.
// - Overtemperature warning reports to fault pin.
// - Setting standby bit enters low-power standby.
// - Bit 6 allows overcurrent clear per cycle.
// - Deglitch code selects 0.2 to 1.6 us.
// - Retry wait 5 ms or 500 ms.
// - Response: latch, retry, report, ignore.
// - Protection register at 0x05 resets 0x46.
// - Overcurrent register at 0x06 resets 0x10.
// - Register at 0x07 resets to zero.
// - Drive register at 0x04 resets 0x80.
// - 110b locks writes, 011b unlocks.
module mdc_control_regs (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  output logic regRvalid,
  output logic serialOutPushPull,
  output logic [1:0] slewCode,
  output logic syncRectify,
  output logic digitalHall,
  output logic faultClearPulse,
  output logic fullDuty40k,
  output logic overvoltageLevel22v,
  output logic overvoltageProtectEn,
  output logic overtempWarnReport,
  output logic driverStandby,
  output logic overcurrentCycleClear,
  output logic [1:0] overcurrentDeglitch,
  output logic overcurrentRetryLong,
  output logic overcurrentLevel24a,
  output logic [1:0] overcurrentResponse,
  output logic overcurrentLatch,
  output logic overcurrentAutoRetry,
  output logic overcurrentReport,
  output logic [7:0] senseRectifyCfg,
  output logic registersLocked
);
  import mdc_pkg::*;

  // ****************************************************************
  // Storage and internal signals.
  // ****************************************************************
  logic [7:0] driveMode_reg;      // Drive type, slew and mode; bit 0 never stored.
  logic [7:0] protection_reg;     // Protection settings.
  logic [7:0] overcurrent_reg;    // Overcurrent and standby settings.
  logic [7:0] rectify_reg;        // Sense and rectification settings.
  logic [7:0] readData_next;      // Read mux value.
  logic [2:0] lockField;          // Lock field readback.
  logic locked;                   // Writes to settings are ignored while set.
  logic settingWrite;             // Write allowed to setting registers.
  logic clearTrigger;             // Write of one to the fault clear bit.

  // Decodes whether an address matches a given target; the lock is checked elsewhere.
  function automatic logic hit(input logic [3:0] addr, input logic [3:0] target);
    hit = (addr == target);
  endfunction

  // ****************************************************************
  // Lock control.
  // ****************************************************************

  // Lock state lives in its own small module.
  mdc_lock_ctrl u_lock (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .writeEn(regWrite),
    .writeAddr(regAddr),
    .writeLow(regWdata[2:0]),
    .lockField(lockField),
    .locked(locked)
  );

  assign settingWrite = regWrite && !locked;

  // ****************************************************************
  // Fault clear command.
  // ****************************************************************

  assign clearTrigger = settingWrite && hit(regAddr, ADDR_DRIVE_MODE) &&
                        regWdata[POS_FAULT_CLEAR];

  // The pulse is high the cycle after each clear write, so back-to-back clear writes hold it high; writing zero gives none.
  mdc_clear_pulse u_clear (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .trigger(clearTrigger),
    .pulse(faultClearPulse)
  );

  // ****************************************************************
  // Setting registers.
  // ****************************************************************

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      driveMode_reg <= RST_DRIVE_MODE;
    end else if (settingWrite && hit(regAddr, ADDR_DRIVE_MODE)) begin
      driveMode_reg <= {regWdata[7:1], 1'b0};
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      protection_reg <= RST_PROTECT;
    end else if (settingWrite && hit(regAddr, ADDR_PROTECT)) begin
      protection_reg <= regWdata & PROTECT_WMASK;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      overcurrent_reg <= RST_OVERCUR;
    end else if (settingWrite && hit(regAddr, ADDR_OVERCUR)) begin
      overcurrent_reg <= regWdata;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rectify_reg <= RST_RECTIFY;
    end else if (settingWrite && hit(regAddr, ADDR_RECTIFY)) begin
      rectify_reg <= regWdata;
    end
  end

  // ****************************************************************
  // Read path.
  // ****************************************************************

  // Selects the read value; unmapped addresses read zero.
  always_comb begin
    case (regAddr)
      ADDR_LOCK: begin
        readData_next = {5'h00, lockField};
      end
      ADDR_DRIVE_MODE: begin
        readData_next = driveMode_reg;
      end
      ADDR_PROTECT: begin
        readData_next = protection_reg;
      end
      ADDR_OVERCUR: begin
        readData_next = overcurrent_reg;
      end
      ADDR_RECTIFY: begin
        readData_next = rectify_reg;
      end
      default: begin
        readData_next = 8'h00;
      end
    endcase
  end

  // Registers read data one cycle after the read strobe.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      regRdata <= 8'h00;
      regRvalid <= 1'b0;
    end else begin
      regRvalid <= regRead;
      if (regRead) begin
        regRdata <= readData_next;
      end
    end
  end

  // ****************************************************************
  // Decoded setting outputs, registered from the current stored value.
  // ****************************************************************

  // Drive type, slew and operating mode fields.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      serialOutPushPull <= 1'b0;
      slewCode <= 2'h0;
      syncRectify <= 1'b0;
      digitalHall <= 1'b0;
    end else begin
      serialOutPushPull <= driveMode_reg[POS_DRIVE_TYPE];
      slewCode <= driveMode_reg[POS_SLEW_LO +: 2];
      syncRectify <= driveMode_reg[POS_MODE_LO + 1];
      digitalHall <= driveMode_reg[POS_MODE_LO];
    end
  end

  // Protection settings.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      fullDuty40k <= 1'b0;
      overvoltageLevel22v <= 1'b0;
      overvoltageProtectEn <= 1'b1;
      overtempWarnReport <= 1'b0;
    end else begin
      fullDuty40k <= protection_reg[POS_FULL_DUTY];
      overvoltageLevel22v <= protection_reg[POS_OV_LEVEL];
      overvoltageProtectEn <= protection_reg[POS_OV_EN];
      overtempWarnReport <= protection_reg[POS_OT_REPORT];
    end
  end

  // Overcurrent and standby settings.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      driverStandby <= 1'b0;
      overcurrentCycleClear <= 1'b0;
      overcurrentDeglitch <= 2'h1;
      overcurrentRetryLong <= 1'b0;
      overcurrentLevel24a <= 1'b0;
      overcurrentResponse <= 2'h0;
    end else begin
      driverStandby <= overcurrent_reg[POS_STANDBY];
      overcurrentCycleClear <= overcurrent_reg[POS_CYCLE_CLEAR];
      overcurrentDeglitch <= overcurrent_reg[POS_DEGLITCH_LO +: 2];
      overcurrentRetryLong <= overcurrent_reg[POS_RETRY];
      overcurrentLevel24a <= overcurrent_reg[POS_OC_LEVEL];
      overcurrentResponse <= overcurrent_reg[POS_OC_RESP_LO +: 2];
    end
  end

  // Overcurrent response decoded into actions.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      overcurrentLatch <= 1'b1;
      overcurrentAutoRetry <= 1'b0;
      overcurrentReport <= 1'b1;
    end else begin
      overcurrentLatch <= (overcurrent_reg[POS_OC_RESP_LO +: 2] == 2'h0);
      overcurrentAutoRetry <= (overcurrent_reg[POS_OC_RESP_LO +: 2] == 2'h1);
      overcurrentReport <= (overcurrent_reg[POS_OC_RESP_LO + 1] == 1'b0) ||
                           (overcurrent_reg[POS_OC_RESP_LO +: 2] == 2'h2);
    end
  end

  // Rectification register copy and lock state.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      senseRectifyCfg <= 8'h00;
      registersLocked <= 1'b0;
    end else begin
      senseRectifyCfg <= rectify_reg;
      registersLocked <= locked;
    end
  end
endmodule

// File: src/mdc_lock_ctrl.sv
// Register lock state holder for the control bank.
`timescale 1ns/10ps
module mdc_lock_ctrl (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic writeEn,
  input wire logic [3:0] writeAddr,
  input wire logic [2:0] writeLow,
  output logic [2:0] lockField,
  output logic locked
);
  import mdc_pkg::*;

  // ****************************************************************
  // Lock field and lock state.
  // ****************************************************************

  // The lock field stores any written code; only two codes change state.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      lockField <= RST_LOCK;
    end else if (writeEn && writeAddr == ADDR_LOCK) begin
      lockField <= writeLow;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      locked <= 1'b0;
    end else if (writeEn && writeAddr == ADDR_LOCK) begin
      if (writeLow == LOCK_CODE) begin
        locked <= 1'b1;
      end else if (writeLow == UNLOCK_CODE) begin
        locked <= 1'b0;
      end
    end
  end
endmodule

// File: src/mdc_pkg.sv
// Package with register map, field layout and reset values of the motor driver control bank.
package mdc_pkg;

  // ****************************************************************
  // Register addresses.
  // ****************************************************************
  localparam logic [3:0] ADDR_LOCK = 4'h3;       // Lock register address.
  localparam logic [3:0] ADDR_DRIVE_MODE = 4'h4; // Drive, slew and mode register.
  localparam logic [3:0] ADDR_PROTECT = 4'h5;    // Protection settings register.
  localparam logic [3:0] ADDR_OVERCUR = 4'h6;    // Overcurrent and standby register.
  localparam logic [3:0] ADDR_RECTIFY = 4'h7;    // Sense and rectification register.

  // ****************************************************************
  // Reset values.
  // ****************************************************************
  localparam logic [7:0] RST_DRIVE_MODE = 8'h80; // Top reserved bits reset to 10b.
  localparam logic [7:0] RST_PROTECT = 8'h46;    // Bits 6, 2 and 1 reset high.
  localparam logic [7:0] RST_OVERCUR = 8'h10;    // Deglitch code 1.
  localparam logic [7:0] RST_RECTIFY = 8'h00;    // All zero.
  localparam logic [2:0] RST_LOCK = 3'h0;        // Lock field after reset.

  // ****************************************************************
  // Lock codes and field positions.
  // ****************************************************************
  localparam logic [2:0] LOCK_CODE = 3'h6;       // 110b locks.
  localparam logic [2:0] UNLOCK_CODE = 3'h3;     // 011b unlocks.
  localparam int POS_DRIVE_TYPE = 5;             // Serial output drive type.
  localparam int POS_SLEW_LO = 3;                // Slew field low bit.
  localparam int POS_MODE_LO = 1;                // Operating mode field low bit.
  localparam int POS_FAULT_CLEAR = 0;            // Fault clear command bit.
  localparam int POS_FULL_DUTY = 4;              // Full-duty frequency select.
  localparam int POS_OV_LEVEL = 3;               // Overvoltage level select.
  localparam int POS_OV_EN = 2;                  // Overvoltage protection enable.
  localparam int POS_OT_REPORT = 0;              // Overtemperature warning report.
  localparam int POS_STANDBY = 7;                // Driver standby.
  localparam int POS_CYCLE_CLEAR = 6;            // Overcurrent cycle clear.
  localparam int POS_DEGLITCH_LO = 4;            // Deglitch field low bit.
  localparam int POS_RETRY = 3;                  // Retry time select.
  localparam int POS_OC_LEVEL = 2;               // Overcurrent level select.
  localparam int POS_OC_RESP_LO = 0;             // Overcurrent response low bit.
  localparam logic [7:0] PROTECT_WMASK = 8'h7f;  // Bit 7 is read-only zero.

endpackage

// File: verification/mdc_control_regs_sva.sv
// Assertion checker for the control register bank ports.
`timescale 1ns/10ps
module mdc_control_regs_sva (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic regWrite,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  input wire logic regRvalid,
  input wire logic faultClearPulse,
  input wire logic serialOutPushPull,
  input wire logic driverStandby,
  input wire logic [1:0] overcurrentResponse,
  input wire logic overcurrentLatch,
  input wire logic overcurrentAutoRetry,
  input wire logic overcurrentReport,
  input wire logic registersLocked
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  clear_pulse_a:
    assert property (regWrite && regAddr == 4'h4 && regWdata[0] && !registersLocked
      && !($past(regWrite) && $past(regAddr) == 4'h3 && $past(regWdata[2:0]) == 3'h6)
      |=> faultClearPulse) else $error("clear write gave no pulse");
  clear_cause_a:
    assert property (faultClearPulse |-> $past(regWrite) && $past(regAddr) == 4'h4
      && $past(regWdata[0])) else $error("pulse without clear write");
  clear_zero_a:
    assert property (regRvalid && $past(regAddr) == 4'h4 |-> !regRdata[0])
      else $error("clear bit read as one");
  prot_top_a:
    assert property (regRvalid && $past(regAddr) == 4'h5 |-> !regRdata[7])
      else $error("bit 7 read as one");
  drive_type_a:
    assert property (regWrite && regAddr == 4'h4 && !registersLocked
      && !($past(regWrite) && $past(regAddr) == 4'h3 && $past(regWdata[2:0]) == 3'h6)
      |-> ##2 serialOutPushPull == $past(regWdata[5], 2)) else $error("drive type wrong");
  resp_decode_a:
    assert property (overcurrentLatch == (overcurrentResponse == 2'h0)
      && overcurrentAutoRetry == (overcurrentResponse == 2'h1)
      && overcurrentReport == (overcurrentResponse != 2'h3)) else $error("decode wrong");
  lock_set_a:
    assert property (regWrite && regAddr == 4'h3 && regWdata[2:0] == 3'h6
      |-> ##[1:2] registersLocked) else $error("lock code did not lock");
  lock_hold_a:
    assert property (registersLocked && regWrite && regAddr == 4'h6
      && !($past(regWrite) && $past(regAddr) == 4'h3 && $past(regWdata[2:0]) == 3'h3)
      |-> ##2 $stable(driverStandby)) else $error("locked write took effect");
endmodule

bind mdc_control_regs mdc_control_regs_sva chk (.clk_sys(clk_sys), .reset_n(reset_n),
  .regWrite(regWrite), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
  .regRvalid(regRvalid), .faultClearPulse(faultClearPulse),
  .serialOutPushPull(serialOutPushPull), .driverStandby(driverStandby),
  .overcurrentResponse(overcurrentResponse), .overcurrentLatch(overcurrentLatch),
  .overcurrentAutoRetry(overcurrentAutoRetry), .overcurrentReport(overcurrentReport),
  .registersLocked(registersLocked));

// File: verification/mdc_control_regs_tb.sv
// Self-checking testbench for the motor driver control register bank.
`timescale 1ns/10ps
module mdc_control_regs_tb;
  logic clk_sys;
  logic reset_n;
  logic regWrite;
  logic regRead;
  logic regRvalid;
  logic fcp; // Fault clear pulse seen at the port.
  logic [3:0] regAddr;
  logic [7:0] regWdata;
  logic [7:0] regRdata;
  logic [28:0] outs; // Decoded settings, packed from the top bit down.
  logic [7:0] m [16]; // Reference copy of every address.
  logic lk; // Reference lock state.
  logic [7:0] rdD;
  logic rdV;
  int n_errors = 0;
  int compares = 0;
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  mdc_control_regs DUT (.clk_sys(clk_sys), .reset_n(reset_n), .regWrite(regWrite),
    .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
    .regRvalid(regRvalid), .serialOutPushPull(outs[28]), .slewCode(outs[27:26]),
    .syncRectify(outs[25]), .digitalHall(outs[24]), .faultClearPulse(fcp),
    .fullDuty40k(outs[23]), .overvoltageLevel22v(outs[22]), .overvoltageProtectEn(outs[21]),
    .overtempWarnReport(outs[20]), .driverStandby(outs[19]), .overcurrentCycleClear(outs[18]),
    .overcurrentDeglitch(outs[17:16]), .overcurrentRetryLong(outs[15]),
    .overcurrentLevel24a(outs[14]), .overcurrentResponse(outs[13:12]),
    .overcurrentLatch(outs[11]), .overcurrentAutoRetry(outs[10]), .overcurrentReport(outs[9]),
    .senseRectifyCfg(outs[8:1]), .registersLocked(outs[0]));
  mdc_host_model host (.clk_sys(clk_sys), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .regRvalid(regRvalid));
  // Counts one comparison and reports a mismatch at once.
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // Compares every decoded setting with the reference copy.
  task automatic chk_out();
    cmp(outs, {m[4][5:1], m[5][4:2], m[5][0], m[6], m[6][1:0] == 2'h0,
      m[6][1:0] == 2'h1, m[6][1:0] != 2'h3, m[7], lk});
  endtask
  // Reads one address and compares the answer and its valid flag.
  task automatic chk_rd(input logic [3:0] a);
    host.rd(a, rdD, rdV);
    cmp({rdV, rdD}, {1'b1, m[a]});
  endtask
  // Writes through the host and updates the reference copy.
  task automatic mwr(input logic [3:0] a, input logic [7:0] dat);
    host.wr(a, dat);
    if (a == 4'h3) begin
      m[3] = {5'h00, dat[2:0]};
      if (dat[2:0] == 3'h6) lk = 1'b1;
      if (dat[2:0] == 3'h3) lk = 1'b0;
    end else if (a >= 4'h4 && a <= 4'h7 && !lk) begin
      m[a] = dat & (a == 4'h4 ? 8'hfe : a == 4'h5 ? 8'h7f : 8'hff);
    end
  endtask
  // Holds reset for ten cycles and loads the reference reset values.
  task automatic do_reset();
    reset_n = 1'b0;
    host.idle(10);
    reset_n = 1'b1;
    m = '{default: 8'h00};
    m[4] = 8'h80;
    m[5] = 8'h46;
    m[6] = 8'h10;
    lk = 1'b0;
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // A hang is cut short and counted as a mismatch.
  initial begin
    #100000;
    n_errors++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(99869));
    do_reset();
    for (int i = 0; i < 16; i++) chk_rd(4'(i));
    chk_out();
    $display("test reset done");
    // Every two-bit code in each field, then random bytes, all back to back.
    for (int a = 4; a < 8; a++) begin
      for (int i = 0; i < 8; i++) mwr(4'(a), i < 4 ? {4{2'(i)}} : 8'($urandom));
      host.idle(2);
      chk_out();
      chk_rd(4'(a));
    end
    $display("test fields done");
    mwr(4'h4, 8'h21);
    host.idle(1);
    cmp(fcp, 1'b1);
    host.idle(1);
    cmp(fcp, 1'b0);
    chk_rd(4'h4);
    $display("test clear done");
    mwr(4'h3, 8'h06);
    host.idle(2);
    mwr(4'h6, 8'hc7);
    mwr(4'h4, 8'h01);
    host.idle(1);
    cmp(fcp, 1'b0);
    mwr(4'h3, 8'h05);
    host.idle(2);
    chk_out();
    chk_rd(4'h3);
    mwr(4'h3, 8'h03);
    host.idle(2);
    mwr(4'h6, 8'hc7);
    host.idle(2);
    chk_out();
    $display("test lock done");
    do_reset();
    chk_out();
    chk_rd(4'h5);
    $display("test second reset done");
    tally_and_finish();
  end
endmodule

// File: verification/mdc_host_model.sv
// Host model that issues register bus cycles at the falling edge.
`timescale 1ns/10ps
module mdc_host_model (
  input wire logic clk_sys,
  output logic regWrite,
  output logic regRead,
  output logic [3:0] regAddr,
  output logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  input wire logic regRvalid
);
  // The bus starts idle.
  initial begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 4'h0;
    regWdata = 8'h00;
  end
  // writes to any register
  // Writes leave the strobe up, so calls in a row run back to back.
  task automatic wr(input logic [3:0] a, input logic [7:0] dat);
    @(negedge clk_sys);
    regRead = 1'b0;
    regWrite = 1'b1;
    regAddr = a;
    regWdata = dat;
  endtask
  // Idle cycles scramble the released data lines so stale data never helps.
  task automatic idle(input int n);
    repeat (n) begin
      @(negedge clk_sys);
      regWrite = 1'b0;
      regRead = 1'b0;
      regWdata = ~regWdata;
    end
  endtask
  // A read takes its answer one cycle after the strobe.
  task automatic rd(input logic [3:0] a, output logic [7:0] dat, output logic v);
    @(negedge clk_sys);
    regWrite = 1'b0;
    regRead = 1'b1;
    regAddr = a;
    @(negedge clk_sys);
    regRead = 1'b0;
    dat = regRdata;
    v = regRvalid;
  endtask
endmodule
